// ==== e1ac_pkg.sv ====
// constants shared by the e1 alarm and common control block
package e1ac_pkg;
  localparam logic [7:0] ADDR_CC2 = 8'h1A;
  localparam logic [7:0] ADDR_CC3 = 8'h1B;
  localparam logic [7:0] ADDR_CC4 = 8'hA8;
  localparam logic [7:0] ADDR_TXMON = 8'hA9;
  localparam logic [7:0] CC2_RESET = 8'h00;
  localparam logic [7:0] CC3_RESET = 8'h00;
  localparam logic [7:0] CC4_RESET = 8'h00;
  localparam logic [7:0] TXMON_RESET = 8'h00;
  localparam logic [7:0] CC2_WMASK = 8'h30;
  localparam logic [7:0] CC3_WMASK = 8'hEF;
  localparam logic [7:0] CC4_WMASK = 8'h9F;
  localparam logic [7:0] RD_ZERO = 8'h00;
  localparam int CC2_AUTO_AIS_ENABLE = 5;
  localparam int CC2_ARA = 4;
  localparam int CC3_TX_ELASTIC_STORE_ENABLE = 7;
  localparam int CC3_TX_CHANNEL_BLOCK_FUNCTION_SELECT = 6;
  localparam int CC3_TX_IDLE_FUNCTION_SELECT = 5;
  localparam int CC3_RX_SIGNALING_REINSERT_ENABLE = 3;
  localparam int CC3_TX_HW_SIGNALING_INSERT_ENABLE = 2;
  localparam int CC3_TX_BACKPLANE_CLOCK_SELECT = 1;
  localparam int CC3_CARRIER_LOSS_ALT_CRITERION = 0;
  localparam int CC4_RLB = 7;
  localparam int TCM_MSB = 4;
  localparam int TCM_LSB = 0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 17;
  localparam int RAI_MF_MS = 128;
  localparam int RAI_CONST_MS = 400;
  localparam int MSE_W = 9;
  localparam int ZCNT_W = 12;
  localparam logic [ZCNT_W-1:0] ZEROS_STD = 12'h0FF;
  localparam logic [ZCNT_W-1:0] ZEROS_ALT = 12'h800;
endpackage : e1ac_pkg

// ==== e1ac_zero_cnt.sv ====
// consecutive zero counter that declares receive carrier loss
`timescale 1ns/100ps
module e1ac_zero_cnt #(
  parameter int CNT_W = e1ac_pkg::ZCNT_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic bit_en,
  input wire logic line_bit,
  input wire logic alt_criterion,
  output logic carrier_loss
);
  import e1ac_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic loss;
  } e1ac_zc_s;

  e1ac_zc_s st_q;
  e1ac_zc_s st_d;
  logic [CNT_W-1:0] limit;

  assign limit = alt_criterion ? CNT_W'(ZEROS_ALT) : CNT_W'(ZEROS_STD);

  always_comb begin
    st_d = st_q;
    if (bit_en) begin
      if (line_bit) begin
        st_d.cnt = '0;
        st_d.loss = 1'b0;
      end else begin
        if (st_q.cnt < limit) begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
        if (st_d.cnt >= limit) begin
          st_d.loss = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign carrier_loss = st_q.loss;

  loss_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(st_q.loss) |-> (st_q.cnt == limit && $past(st_q.cnt) == limit - 1'b1))
    else $error("carrier loss declared at wrong zero count");
  loss_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (bit_en && line_bit) |=> (!st_q.loss && st_q.cnt == '0))
    else $error("carrier loss not cleared by a one");
endmodule : e1ac_zero_cnt

// ==== e1ac_top.sv ====
// e1 automatic alarm generation and common control registers
// Overview of operation
// - auto ais on: send all ones on sync loss, ais received, or carrier loss
// - auto rai on, auto ais off: send rai on those conditions or crc4 multiframe missing 128 ms
// - auto rai on, auto ais off, crc4 multiframe still missing at 400 ms: rai held continuously
// - elastic store enable bit picks bypass or elastic store transmit data
// - reinsert bit set puts signaling bits into the receive serial output
// - hardware signaling bit set inserts signaling input into transmit data
// - carrier loss after 255 zeros, or 2048 zeros with alternate bit set
// - remote loopback bit enables loopback of receive data to transmit line
// - five bit field picks transmit channel copied into the monitor register
// - automatic remote alarm enable bit clear disables auto rai, set enables it while the auto ais bit is clear
`timescale 1ns/100ps
module e1ac_top #(
  parameter int MS_CYCLES = e1ac_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic host_cs_n,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic rx_loss_of_sync,
  input wire logic rx_ais_detect,
  input wire logic rx_fas_sync,
  input wire logic rx_crc4_enable,
  input wire logic rx_crc4_mf_sync,
  input wire logic rx_bit_en,
  input wire logic rx_line_bit,
  input wire logic rx_sig_slot,
  input wire logic rx_sig_bit,
  input wire logic tx_bit_en,
  input wire logic tx_serial_in,
  input wire logic tx_es_data,
  input wire logic tx_signaling_in,
  input wire logic tx_sig_slot,
  input wire logic tx_rai_slot,
  input wire logic tx_byte_valid,
  input wire logic [4:0] tx_channel_index,
  input wire logic [7:0] tx_channel_byte,
  output logic rx_carrier_loss,
  output logic rx_serial_out,
  output logic tx_line_out,
  output logic tx_send_ais,
  output logic tx_send_rai,
  output logic tx_elastic_store_enable,
  output logic tx_channel_block_function_select,
  output logic tx_idle_function_select,
  output logic rx_signaling_reinsert_enable,
  output logic tx_hw_signaling_insert_enable,
  output logic tx_backplane_clock_select,
  output logic remote_loopback_enable,
  output logic [4:0] tx_monitor_channel
);
  import e1ac_pkg::*;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic rd_s1;
    logic rd_s2;
    logic [7:0] addr_s1;
    logic [7:0] addr_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic [7:0] cc2;
    logic [7:0] cc3;
    logic [7:0] cc4;
    logic [7:0] txmon;
    logic [7:0] dout;
    logic drv_n;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [MSE_W-1:0] ms_elapsed;
    logic const_rai;
    logic send_ais;
    logic send_rai;
    logic tx_line;
    logic rx_out;
  } e1ac_state_s;

  localparam e1ac_state_s ST_RST = '{drv_n: 1'b1, cc2: CC2_RESET, cc3: CC3_RESET,
                                     cc4: CC4_RESET, txmon: TXMON_RESET, default: '0};

  e1ac_state_s st_q;
  e1ac_state_s st_d;
  logic carrier_loss;
  logic rx_cond;
  logic timer_run;
  logic wr_fall;
  logic rd_act;
  logic tx_fmt;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
    return a == t;
  endfunction : addr_hit

  e1ac_zero_cnt #(
    .CNT_W(ZCNT_W)
  ) u_zero_cnt (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .bit_en(rx_bit_en),
    .line_bit(rx_line_bit),
    .alt_criterion(st_q.cc3[CC3_CARRIER_LOSS_ALT_CRITERION]),
    .carrier_loss(carrier_loss)
  );

  assign rx_cond = rx_loss_of_sync | rx_ais_detect | carrier_loss;
  assign timer_run = rx_fas_sync & rx_crc4_enable & ~rx_crc4_mf_sync;
  assign wr_fall = st_q.wr_s2 & ~st_q.wr_s3 & st_q.cs_s2;
  assign rd_act = st_q.rd_s2 & st_q.cs_s2;

  always_comb begin
    st_d = st_q;
    // host strobes held active high inside the synchronisers
    st_d.cs_s1 = ~host_cs_n;
    st_d.cs_s2 = st_q.cs_s1;
    st_d.wr_s1 = ~host_wr_n;
    st_d.wr_s2 = st_q.wr_s1;
    st_d.wr_s3 = st_q.wr_s2;
    st_d.rd_s1 = ~host_rd_n;
    st_d.rd_s2 = st_q.rd_s1;
    st_d.addr_s1 = host_addr;
    st_d.addr_s2 = st_q.addr_s1;
    st_d.din_s1 = host_data_in;
    st_d.din_s2 = st_q.din_s1;

    if (wr_fall) begin
      if (addr_hit(st_q.addr_s2, ADDR_CC2)) begin
        st_d.cc2 = st_q.din_s2 & CC2_WMASK;
      end
      if (addr_hit(st_q.addr_s2, ADDR_CC3)) begin
        st_d.cc3 = st_q.din_s2 & CC3_WMASK;
      end
      if (addr_hit(st_q.addr_s2, ADDR_CC4)) begin
        st_d.cc4 = st_q.din_s2 & CC4_WMASK;
      end
    end

    st_d.drv_n = ~rd_act;
    if (!rd_act) begin
      st_d.dout = RD_ZERO;
    end else if (addr_hit(st_q.addr_s2, ADDR_CC2)) begin
      st_d.dout = st_q.cc2;
    end else if (addr_hit(st_q.addr_s2, ADDR_CC3)) begin
      st_d.dout = st_q.cc3;
    end else if (addr_hit(st_q.addr_s2, ADDR_CC4)) begin
      st_d.dout = st_q.cc4;
    end else if (addr_hit(st_q.addr_s2, ADDR_TXMON)) begin
      st_d.dout = st_q.txmon;
    end else begin
      st_d.dout = RD_ZERO;
    end

    if (tx_byte_valid && tx_channel_index == st_q.cc4[TCM_MSB:TCM_LSB]) begin
      st_d.txmon = tx_channel_byte;
    end

    // millisecond timer for crc4 multiframe search after fas alignment
    if (!timer_run) begin
      st_d.ms_cnt = '0;
      st_d.ms_elapsed = '0;
    end else if (st_q.ms_cnt == MS_CNT_W'(MS_CYCLES - 1)) begin
      st_d.ms_cnt = '0;
      if (st_q.ms_elapsed < MSE_W'(RAI_CONST_MS)) begin
        st_d.ms_elapsed = st_q.ms_elapsed + 1'b1;
      end
    end else begin
      st_d.ms_cnt = st_q.ms_cnt + 1'b1;
    end
    if (rx_crc4_mf_sync || !rx_crc4_enable) begin
      st_d.const_rai = 1'b0;
    end else if (st_d.ms_elapsed >= MSE_W'(RAI_CONST_MS)) begin
      st_d.const_rai = 1'b1;
    end

    st_d.send_ais = st_q.cc2[CC2_AUTO_AIS_ENABLE] & rx_cond;
    st_d.send_rai = st_q.cc2[CC2_ARA] & ~st_q.cc2[CC2_AUTO_AIS_ENABLE]
      & (rx_cond | (st_q.ms_elapsed >= MSE_W'(RAI_MF_MS)) | st_q.const_rai);

    if (tx_bit_en) begin
      tx_fmt = st_q.cc3[CC3_TX_ELASTIC_STORE_ENABLE] ? tx_es_data : tx_serial_in;
      if (st_q.cc3[CC3_TX_HW_SIGNALING_INSERT_ENABLE] && tx_sig_slot) begin
        tx_fmt = tx_signaling_in;
      end
      if (st_q.send_rai && tx_rai_slot) begin
        tx_fmt = 1'b1;
      end
      if (st_q.send_ais) begin
        tx_fmt = 1'b1;
      end
      st_d.tx_line = st_q.cc4[CC4_RLB] ? rx_line_bit : tx_fmt;
    end else begin
      tx_fmt = 1'b0;
    end

    if (rx_bit_en) begin
      st_d.rx_out = (st_q.cc3[CC3_RX_SIGNALING_REINSERT_ENABLE] && rx_sig_slot) ? rx_sig_bit : rx_line_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign host_data_out = st_q.dout;
  assign host_data_oe_n = st_q.drv_n;
  assign rx_carrier_loss = carrier_loss;
  assign rx_serial_out = st_q.rx_out;
  assign tx_line_out = st_q.tx_line;
  assign tx_send_ais = st_q.send_ais;
  assign tx_send_rai = st_q.send_rai;
  assign tx_elastic_store_enable = st_q.cc3[CC3_TX_ELASTIC_STORE_ENABLE];
  assign tx_channel_block_function_select = st_q.cc3[CC3_TX_CHANNEL_BLOCK_FUNCTION_SELECT];
  assign tx_idle_function_select = st_q.cc3[CC3_TX_IDLE_FUNCTION_SELECT];
  assign rx_signaling_reinsert_enable = st_q.cc3[CC3_RX_SIGNALING_REINSERT_ENABLE];
  assign tx_hw_signaling_insert_enable = st_q.cc3[CC3_TX_HW_SIGNALING_INSERT_ENABLE];
  assign tx_backplane_clock_select = st_q.cc3[CC3_TX_BACKPLANE_CLOCK_SELECT];
  assign remote_loopback_enable = st_q.cc4[CC4_RLB];
  assign tx_monitor_channel = st_q.cc4[TCM_MSB:TCM_LSB];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence host_write_cc3;
    wr_fall && addr_hit(st_q.addr_s2, ADDR_CC3);
  endsequence
  sequence host_read_cc4;
    rd_act && addr_hit(st_q.addr_s2, ADDR_CC4);
  endsequence

  ais_on_cond_a: assert property ((st_q.cc2[CC2_AUTO_AIS_ENABLE] && rx_cond) |=> st_q.send_ais)
    else $error("ais not sent on receive condition");
  rai_on_cond_a: assert property (
    (st_q.cc2[CC2_ARA] && !st_q.cc2[CC2_AUTO_AIS_ENABLE] && rx_cond) |=> st_q.send_rai)
    else $error("rai not sent on receive condition");
  rai_mf_miss_a: assert property (
    (st_q.cc2[CC2_ARA] && !st_q.cc2[CC2_AUTO_AIS_ENABLE] && st_q.ms_elapsed >= RAI_MF_MS) |=> st_q.send_rai)
    else $error("rai not sent on multiframe search timeout");
  const_rai_set_a: assert property ($rose(st_q.const_rai) |-> st_q.ms_elapsed == RAI_CONST_MS)
    else $error("constant rai latched at wrong time");
  no_auto_alarm_a: assert property (
    (!st_q.cc2[CC2_AUTO_AIS_ENABLE] && !st_q.cc2[CC2_ARA]) |=> (!st_q.send_ais && !st_q.send_rai))
    else $error("alarm sent with both auto enables clear");
  cc3_write_a: assert property (host_write_cc3 |=> st_q.cc3 == ($past(st_q.din_s2) & CC3_WMASK))
    else $error("common control three write mismatch");
  cc4_read_a: assert property (host_read_cc4 ##1 1'b1 |-> (!host_data_oe_n && host_data_out == $past(st_q.cc4)))
    else $error("common control four read mismatch");
  monitor_copy_a: assert property (
    (tx_byte_valid && tx_channel_index == st_q.cc4[TCM_MSB:TCM_LSB]) |=> st_q.txmon == $past(tx_channel_byte))
    else $error("monitor byte not captured");
  loopback_a: assert property ((tx_bit_en && st_q.cc4[CC4_RLB]) |=> tx_line_out == $past(rx_line_bit))
    else $error("remote loopback data mismatch");
  ais_ones_a: assert property ((tx_bit_en && !st_q.cc4[CC4_RLB] && st_q.send_ais) |=> tx_line_out)
    else $error("ais bit not all ones");
  reinsert_a: assert property (
    (rx_bit_en && st_q.cc3[CC3_RX_SIGNALING_REINSERT_ENABLE] && rx_sig_slot) |=> rx_serial_out == $past(rx_sig_bit))
    else $error("signaling not reinserted");
  sig_insert_a: assert property (
    (tx_bit_en && !st_q.cc4[CC4_RLB] && !st_q.send_ais && !st_q.send_rai && st_q.cc3[CC3_TX_HW_SIGNALING_INSERT_ENABLE]
     && tx_sig_slot) |=> tx_line_out == $past(tx_signaling_in))
    else $error("signaling not inserted");
endmodule : e1ac_top

// ==== e1ac_host_model.sv ====
// host processor model driving the parallel control port
`timescale 1ns/100ps
module e1ac_host_model (
  input wire logic ref_clk,
  output logic host_cs_n,
  output logic host_wr_n,
  output logic host_rd_n,
  output logic [7:0] host_addr,
  output wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_n
);
  logic [7:0] bus_q;
  // shared data wire: the device drives it while its enable is low
  assign host_data_in = host_data_oe_n ? bus_q : host_data_out;
  initial begin
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    host_addr = 8'h00;
    bus_q = 8'h5A;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_cs_n <= 1'b0;
    host_wr_n <= 1'b0;
    host_addr <= a;
    bus_q <= d;
    repeat (5) @(posedge ref_clk);
    host_cs_n <= 1'b1;
    host_wr_n <= 1'b1;
    // released lines show no stale value
    host_addr <= ~a;
    bus_q <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk);
    host_cs_n <= 1'b0;
    host_rd_n <= 1'b0;
    host_addr <= a;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (host_data_oe_n !== 1'b0 && n < 10);
    d = host_data_out;
    host_cs_n <= 1'b1;
    host_rd_n <= 1'b1;
    host_addr <= ~a;
    repeat (5) @(posedge ref_clk);
  endtask : rd
endmodule : e1ac_host_model

// ==== test_e1_alarm_and_common_control.sv ====
// self-checking bench for the e1 alarm and common control block
`timescale 1ns/100ps
module test_e1_alarm_and_common_control;
  import e1ac_pkg::*;
  localparam int MSC = 8;
  logic ref_clk, reset_n, host_cs_n, host_wr_n, host_rd_n, host_data_oe_n;
  logic [7:0] host_addr, host_data_out, tx_channel_byte, rd_v;
  wire logic [7:0] host_data_in;
  logic rx_loss_of_sync, rx_ais_detect, rx_fas_sync, rx_crc4_enable, rx_crc4_mf_sync;
  logic rx_bit_en, rx_line_bit, rx_sig_slot, rx_sig_bit, tx_bit_en, tx_serial_in;
  logic tx_es_data, tx_signaling_in, tx_sig_slot, tx_rai_slot, tx_byte_valid;
  logic [4:0] tx_channel_index, tx_monitor_channel;
  logic rx_carrier_loss, rx_serial_out, tx_line_out, tx_send_ais, tx_send_rai;
  logic [6:0] cfg;
  int errors, n_tests;
  e1ac_top #(.MS_CYCLES(MSC)) i_dut (.ref_clk, .reset_n, .host_cs_n, .host_wr_n,
    .host_rd_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe_n,
    .rx_loss_of_sync, .rx_ais_detect, .rx_fas_sync, .rx_crc4_enable, .rx_crc4_mf_sync,
    .rx_bit_en, .rx_line_bit, .rx_sig_slot, .rx_sig_bit, .tx_bit_en, .tx_serial_in,
    .tx_es_data, .tx_signaling_in, .tx_sig_slot, .tx_rai_slot, .tx_byte_valid,
    .tx_channel_index, .tx_channel_byte, .rx_carrier_loss, .rx_serial_out, .tx_line_out,
    .tx_send_ais, .tx_send_rai, .tx_elastic_store_enable(cfg[6]),
    .tx_channel_block_function_select(cfg[5]), .tx_idle_function_select(cfg[4]),
    .rx_signaling_reinsert_enable(cfg[3]), .tx_hw_signaling_insert_enable(cfg[2]),
    .tx_backplane_clock_select(cfg[1]), .remote_loopback_enable(cfg[0]),
    .tx_monitor_channel);
  e1ac_host_model i_host (.ref_clk, .host_cs_n, .host_wr_n, .host_rd_n, .host_addr,
    .host_data_in, .host_data_out, .host_data_oe_n);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic creg(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, rd_v);
    chk(rd_v, exp);
  endtask : creg
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // one bit on both paths, returns once the answer has settled
  task automatic step(input logic b);
    @(posedge ref_clk);
    rx_line_bit <= b;
    rx_bit_en <= 1'b1;
    tx_bit_en <= 1'b1;
    @(posedge ref_clk);
    rx_bit_en <= 1'b0;
    tx_bit_en <= 1'b0;
    cyc(2);
  endtask : step
  task automatic txbyte(input logic [4:0] i, input logic [7:0] b);
    @(posedge ref_clk);
    tx_byte_valid <= 1'b1;
    tx_channel_index <= i;
    tx_channel_byte <= b;
    @(posedge ref_clk);
    tx_byte_valid <= 1'b0;
  endtask : txbyte
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    {rx_loss_of_sync, rx_ais_detect, rx_fas_sync, rx_crc4_enable, rx_crc4_mf_sync} = '0;
    {rx_bit_en, rx_line_bit, rx_sig_slot, rx_sig_bit, tx_bit_en, tx_serial_in} = '0;
    {tx_es_data, tx_signaling_in, tx_sig_slot, tx_rai_slot, tx_byte_valid} = '0;
    tx_channel_index = 5'h00;
    tx_channel_byte = 8'h00;
    cyc(8);
    reset_n <= 1'b1;
    cyc(3);
    creg(ADDR_CC2, CC2_RESET);
    creg(ADDR_CC3, CC3_RESET);
    creg(ADDR_CC4, CC4_RESET);
    creg(ADDR_TXMON, TXMON_RESET);
    // unassigned bits written as ones on purpose, both auto enables left clear
    i_host.wr(ADDR_CC2, 8'hCF);
    creg(ADDR_CC2, 8'h00);
    i_host.wr(ADDR_CC3, 8'hFF);
    creg(ADDR_CC3, 8'hEF);
    chk({1'b0, cfg}, 8'h7E);
    i_host.wr(ADDR_CC4, 8'hFF);
    creg(ADDR_CC4, 8'h9F);
    chk({3'h0, tx_monitor_channel}, 8'h1F);
    creg(8'h55, RD_ZERO);
    i_host.wr(ADDR_TXMON, 8'h77);
    txbyte(5'h1E, 8'hA5);
    txbyte(5'h1F, 8'h3C);
    creg(ADDR_TXMON, 8'h3C);
    i_host.wr(ADDR_CC4, 8'h85);
    txbyte(5'h05, 8'hC3);
    creg(ADDR_TXMON, 8'hC3);
    step(1'b1);
    chk(tx_line_out, 8'h01);
    i_host.wr(ADDR_CC4, 8'h00);
    tx_serial_in <= 1'b1;
    tx_sig_slot <= 1'b1;
    rx_sig_slot <= 1'b1;
    rx_sig_bit <= 1'b1;
    i_host.wr(ADDR_CC3, 8'h00);
    step(1'b0);
    chk({rx_serial_out, tx_line_out}, 8'h01);
    i_host.wr(ADDR_CC3, 8'h80);
    step(1'b0);
    chk(tx_line_out, 8'h00);
    i_host.wr(ADDR_CC3, 8'h0C);
    step(1'b0);
    chk({rx_serial_out, tx_line_out}, 8'h02);
    i_host.wr(ADDR_CC2, 8'h20);
    for (int m = 0; m < 2; m++) begin
      i_host.wr(ADDR_CC3, m[7:0]);
      step(1'b1);
      repeat (m ? 2047 : 254) step(1'b0);
      chk(rx_carrier_loss, 8'h00);
      step(1'b0);
      chk(rx_carrier_loss, 8'h01);
      cyc(2);
      chk(tx_send_ais, 8'h01);
      step(1'b1);
      chk(rx_carrier_loss, 8'h00);
    end
    for (int c = 0; c < 2; c++) begin
      if (c == 0) rx_loss_of_sync <= 1'b1;
      else rx_ais_detect <= 1'b1;
      cyc(3);
      chk({tx_send_rai, tx_send_ais}, 8'h01);
      rx_loss_of_sync <= 1'b0;
      rx_ais_detect <= 1'b0;
      cyc(3);
      chk(tx_send_ais, 8'h00);
    end
    i_host.wr(ADDR_CC2, 8'h10);
    rx_loss_of_sync <= 1'b1;
    cyc(3);
    chk({tx_send_rai, tx_send_ais}, 8'h02);
    // remote alarm forces ones into its slot even with zero transmit data
    tx_serial_in <= 1'b0;
    tx_sig_slot <= 1'b0;
    tx_rai_slot <= 1'b1;
    step(1'b1);
    chk(tx_line_out, 8'h01);
    tx_rai_slot <= 1'b0;
    step(1'b1);
    chk(tx_line_out, 8'h00);
    rx_loss_of_sync <= 1'b0;
    rx_crc4_enable <= 1'b1;
    cyc(3);
    chk(tx_send_rai, 8'h00);
    for (int k = 0; k < 2; k++) begin
      rx_fas_sync <= 1'b1;
      cyc(1000);
      chk(tx_send_rai, 8'h00);
      cyc(k ? 2240 : 2090);
      chk(tx_send_rai, 8'h01);
      rx_fas_sync <= 1'b0;
      cyc(5);
      chk(tx_send_rai, k[7:0]);
    end
    rx_crc4_mf_sync <= 1'b1;
    cyc(5);
    chk(tx_send_rai, 8'h00);
    i_host.wr(ADDR_CC2, 8'h00);
    rx_loss_of_sync <= 1'b1;
    rx_ais_detect <= 1'b1;
    cyc(4);
    chk({tx_send_rai, tx_send_ais}, 8'h00);
    print_verdict();
  end
endmodule : test_e1_alarm_and_common_control
